/* dsp_regs.vh */
`ifndef DSP_REGS_VH
`define DSP_REGS_VH
// ----------------------------------------
// Register pointer codes
// ----------------------------------------
`define DSP_PTR_CMD      3'h0
`define DSP_PTR_MODE     3'h1
`define DSP_PTR_VEC      3'h2
`define DSP_PTR_RXP      3'h3
`define DSP_PTR_MISC     3'h4
`define DSP_PTR_TXP      3'h5
// ----------------------------------------
// Command field and codes
// ----------------------------------------
`define DSP_CMD_MSB      5
`define DSP_CMD_LSB      3
`define DSP_CMD_EXT_RST  3'h2
`define DSP_CMD_CH_RST   3'h3
`define DSP_CMD_RX_NEXT  3'h4
`define DSP_CMD_TXIP_RST 3'h5
`define DSP_CMD_ERR_RST  3'h6
`define DSP_CMD_RETURN_FROM_IRQ_OPCODE     3'h7
// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define DSP_MODE_EXTIE   0
`define DSP_MODE_TXIE    1
`define DSP_MODE_SAV     2
`define DSP_MODE_RXM_LSB 3
`define DSP_MODE_RXM_MSB 4
`define DSP_RXM_OFF      2'h0
`define DSP_RXM_FIRST    2'h1
`define DSP_RXP_RXEN     0
`define DSP_TXP_TXEN     3
// ----------------------------------------
// Status fields
// ----------------------------------------
`define DSP_RR0_RXAV     0
`define DSP_RR0_IP       1
`define DSP_RR0_TXE      2
`define DSP_RR0_DCD      3
`define DSP_RR0_RI       4
`define DSP_RR0_CTS      5
`define DSP_RR1_SENT     0
`define DSP_RR1_OVR      5
`define DSP_RR1_FE       6
// ----------------------------------------
// Vector source codes, reset values, counts
// ----------------------------------------
`define DSP_VSRC_TX      2'h0
`define DSP_VSRC_EXT     2'h1
`define DSP_VSRC_RX      2'h2
`define DSP_VSRC_SP      2'h3
`define DSP_CFG_RST      8'h00
`define DSP_VEC_RST      8'h00
`define DSP_RETURN_FROM_IRQ_OPCODE_B0      8'hED
`define DSP_RETURN_FROM_IRQ_OPCODE_B1      8'h4D
`define DSP_FIFO_DEPTH   2'h3
`define DSP_TX_BITS      4'hA
`define DSP_RX_STOP      4'h9
`endif

/* dsp_host_port.v */
`include "dsp_regs.vh"
module dsp_host_port #(
   parameter [15:0] BIT_DIV = 16'h0010
) (
   input  wire       mclk_in,
   input  wire       rst_b_in,
   input  wire       chip_sel_n_in,
   input  wire       rd_n_in,
   input  wire       io_request_strobe_n_in,
   input  wire       opcode_fetch_strobe_n_in,
   input  wire       chan_b_sel_in,
   input  wire       ctrl_sel_in,
   input  wire [7:0] data_in,
   input  wire       chain_enable_in,
   input  wire [1:0] cts_n_in,
   input  wire [1:0] dcd_n_in,
   input  wire [1:0] ring_indicator_n_in,
   input  wire [1:0] rxd_in,
   output wire [7:0] data_out,
   output wire       data_oe_n_out,
   output wire       irq_n_out,
   output wire       irq_oe_n_out,
   output wire       chain_enable_out,
   output wire [1:0] txd_out
);
// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
reg  [22:0] s1_q;
reg  [22:0] s2_q;
always @(posedge mclk_in or negedge rst_b_in) begin
   if (!rst_b_in) begin
      s1_q <= 23'h7FFFFF;
      s2_q <= 23'h7FFFFF;
   end else begin
      s1_q <= {rxd_in, ring_indicator_n_in, dcd_n_in, cts_n_in, data_in, chain_enable_in,
               ctrl_sel_in, chan_b_sel_in, opcode_fetch_strobe_n_in, io_request_strobe_n_in,
               rd_n_in, chip_sel_n_in};
      s2_q <= s1_q;
   end
end
wire       ce_n_w  = s2_q[0];
wire       rd_n_w  = s2_q[1];
wire       io_request_strobe_n_n_w = s2_q[2];
wire       m1_n_w  = s2_q[3];
wire       bsel_w  = s2_q[4];
wire       csel_w  = s2_q[5];
wire       chain_w = s2_q[6];
wire [7:0] d_w     = s2_q[14:7];
wire [1:0] cts_w   = ~s2_q[16:15];
wire [1:0] dcd_w   = ~s2_q[18:17];
wire [1:0] ri_w    = ~s2_q[20:19];
wire [1:0] rxd_w   = s2_q[22:21];
// ----------------------------------------
// State
// ----------------------------------------
reg  [2:0]  ptr_q  [0:1];
reg  [7:0]  mode_q [0:1], rxp_q [0:1], misc_q [0:1], txp_q [0:1], thr_q [0:1];
reg  [8:0]  tsh_q  [0:1];
reg  [3:0]  tcnt_q [0:1];
reg  [15:0] rdiv_q [0:1];
reg  [3:0]  rcnt_q [0:1];
reg  [7:0]  rsh_q  [0:1];
reg  [1:0]  fcnt_q [0:1];
reg  [2:0]  mprev_q [0:1];
reg  [7:0]  fifo_q [0:5];
reg  [7:0]  vec_q;
reg  [15:0] tdiv_q;
reg  [1:0]  thr_full_q, rbusy_q, ovr_q, fe_q, arm_q, first_q, txip_q, extip_q, txd_q;
reg  [5:0]  ip_q, ius_q;
reg         acc_q, ack_q, m1_q, prev_ed_q;
reg  [7:0]  dout_q;
reg         doe_n_q, irq_n_q, chain_out_q;
// ----------------------------------------
// Host cycle decode
// ----------------------------------------
wire       acc_w    = ~ce_n_w & ~io_request_strobe_n_n_w & m1_n_w;
wire       ack_w    = ~m1_n_w & ~io_request_strobe_n_n_w;
wire       acc_st_w = acc_w & ~acc_q;
wire       wr_st_w  = acc_st_w & rd_n_w;
wire       rd_st_w  = acc_st_w & ~rd_n_w;
wire       ack_st_w = ack_w & ~ack_q;
wire       fetch_end_w = m1_n_w & ~m1_q & io_request_strobe_n_n_w;
wire       return_from_irq_opcode_bus_w = fetch_end_w & prev_ed_q & (d_w == `DSP_RETURN_FROM_IRQ_OPCODE_B1);
wire [2:0] cmd_w    = d_w[`DSP_CMD_MSB:`DSP_CMD_LSB];
wire       cmd_st_w = wr_st_w & csel_w & (ptr_q[bsel_w] == `DSP_PTR_CMD);
wire       tick_w   = (tdiv_q == 16'h0000);
// ----------------------------------------
// Receive, status and priority
// ----------------------------------------
reg  [1:0] push_c, pop_c, spc_c;
reg  [5:0] ip_raw;
reg  [7:0] rr0_c [0:1];
reg  [7:0] rr1_c [0:1];
reg  [7:0] rd_val, vec_out;
reg  [1:0] src_code;
reg  [2:0] sel;
reg        hit, blk;
reg  [1:0] rxm;
integer    c, i, n, m;
always @* begin
   rxm = 2'h0;
   for (n = 0; n < 2; n = n + 1) begin
      rxm = mode_q[n][`DSP_MODE_RXM_MSB:`DSP_MODE_RXM_LSB];
      push_c[n] = rbusy_q[n] & (rdiv_q[n] == 16'h0000) & (rcnt_q[n] == `DSP_RX_STOP);
      pop_c[n]  = rd_st_w & ~csel_w & (bsel_w == n[0]) & (fcnt_q[n] != 2'h0);
      spc_c[n]  = (rxm != `DSP_RXM_OFF) & (ovr_q[n] | fe_q[n]);
      ip_raw[n*3]   = spc_c[n] | ((rxm == `DSP_RXM_FIRST) ? first_q[n]
                                  : (rxm[1] & (fcnt_q[n] != 2'h0)));
      ip_raw[n*3+1] = txip_q[n];
      ip_raw[n*3+2] = extip_q[n];
      rr0_c[n] = 8'h00;
      rr0_c[n][`DSP_RR0_RXAV] = (fcnt_q[n] != 2'h0);
      rr0_c[n][`DSP_RR0_IP]   = (n == 0) & (|ip_q);
      rr0_c[n][`DSP_RR0_TXE]  = ~thr_full_q[n];
      rr0_c[n][`DSP_RR0_DCD]  = dcd_w[n];
      rr0_c[n][`DSP_RR0_RI]   = ri_w[n];
      rr0_c[n][`DSP_RR0_CTS]  = cts_w[n];
      rr1_c[n] = 8'h00;
      rr1_c[n][`DSP_RR1_SENT] = (tcnt_q[n] == 4'h0) & ~thr_full_q[n];
      rr1_c[n][`DSP_RR1_OVR]  = ovr_q[n];
      rr1_c[n][`DSP_RR1_FE]   = fe_q[n];
   end
   blk = 1'b0;
   hit = 1'b0;
   sel = 3'h0;
   for (m = 0; m < 6; m = m + 1) begin
      blk = blk | ius_q[m];
      if (!blk && !hit && ip_q[m]) begin
         hit = 1'b1;
         sel = m[2:0];
      end
   end
   case (sel)
      3'h0, 3'h3: src_code = spc_c[sel >= 3'h3] ? `DSP_VSRC_SP : `DSP_VSRC_RX;
      3'h1, 3'h4: src_code = `DSP_VSRC_TX;
      default:    src_code = hit ? `DSP_VSRC_EXT : `DSP_VSRC_SP;
   endcase
   if (mode_q[1][`DSP_MODE_SAV])
      vec_out = {vec_q[7:4], (sel < 3'h3) & hit, src_code, vec_q[0]};
   else
      vec_out = vec_q;
   if (!csel_w)
      rd_val = fifo_q[bsel_w ? 3 : 0];
   else begin
      case (ptr_q[bsel_w])
         `DSP_PTR_CMD:  rd_val = rr0_c[bsel_w];
         `DSP_PTR_MODE: rd_val = rr1_c[bsel_w];
         `DSP_PTR_VEC:  rd_val = bsel_w ? vec_out : 8'h00;
         default:       rd_val = 8'h00;
      endcase
   end
end
// ----------------------------------------
// Registers, channels and interrupt control
// ----------------------------------------
wire [5:0] ius_low_w = ius_q & (~ius_q + 6'h01);
wire       return_from_irq_opcode_w    = return_from_irq_opcode_bus_w | (cmd_st_w & ~bsel_w & (cmd_w == `DSP_CMD_RETURN_FROM_IRQ_OPCODE));
always @(posedge mclk_in or negedge rst_b_in) begin
   if (!rst_b_in) begin
      for (c = 0; c < 2; c = c + 1) begin
         ptr_q[c]   <= `DSP_PTR_CMD;
         {mode_q[c], rxp_q[c], misc_q[c], txp_q[c]} <= {4{`DSP_CFG_RST}};
         thr_q[c]   <= 8'h00;
         tsh_q[c]   <= 9'h1FF;
         tcnt_q[c]  <= 4'h0;
         rdiv_q[c]  <= 16'h0000;
         rcnt_q[c]  <= 4'h0;
         rsh_q[c]   <= 8'h00;
         fcnt_q[c]  <= 2'h0;
         mprev_q[c] <= 3'h0;
      end
      for (i = 0; i < 6; i = i + 1)
         fifo_q[i] <= 8'h00;
      vec_q <= `DSP_VEC_RST;
      tdiv_q <= 16'h0000;
      {thr_full_q, rbusy_q, ovr_q, fe_q, first_q, txip_q, extip_q} <= 14'h0000;
      arm_q <= 2'h3;
      txd_q <= 2'h3;
      ip_q <= 6'h00;
      ius_q <= 6'h00;
      {acc_q, ack_q, m1_q, prev_ed_q} <= 4'hA;
      dout_q <= 8'h00;
      doe_n_q <= 1'b1;
      irq_n_q <= 1'b1;
      chain_out_q <= 1'b0;
   end else begin
      acc_q <= acc_w;
      ack_q <= ack_w;
      m1_q <= m1_n_w;
      if (fetch_end_w)
         prev_ed_q <= (d_w == `DSP_RETURN_FROM_IRQ_OPCODE_B0);
      tdiv_q <= tick_w ? BIT_DIV - 16'h0001 : tdiv_q - 16'h0001;
      for (c = 0; c < 2; c = c + 1) begin
         // Transmitter
         if (tcnt_q[c] == 4'h0) begin
            if (thr_full_q[c] && txp_q[c][`DSP_TXP_TXEN]) begin
               tsh_q[c] <= {thr_q[c], 1'b0};
               tcnt_q[c] <= `DSP_TX_BITS;
               thr_full_q[c] <= 1'b0;
            end
         end else if (tick_w) begin
            txd_q[c] <= tsh_q[c][0];
            tsh_q[c] <= {1'b1, tsh_q[c][8:1]};
            tcnt_q[c] <= tcnt_q[c] - 4'h1;
         end
         // Receiver
         if (!rbusy_q[c]) begin
            if (rxp_q[c][`DSP_RXP_RXEN] && !rxd_w[c]) begin
               rbusy_q[c] <= 1'b1;
               rdiv_q[c] <= {1'b0, BIT_DIV[15:1]};
               rcnt_q[c] <= 4'h0;
            end
         end else if (rdiv_q[c] != 16'h0000) begin
            rdiv_q[c] <= rdiv_q[c] - 16'h0001;
         end else begin
            rdiv_q[c] <= BIT_DIV - 16'h0001;
            rcnt_q[c] <= rcnt_q[c] + 4'h1;
            if (rcnt_q[c] == 4'h0 && rxd_w[c])
               rbusy_q[c] <= 1'b0;
            else if (rcnt_q[c] < `DSP_RX_STOP)
               rsh_q[c] <= {rxd_w[c], rsh_q[c][7:1]};
            else
               rbusy_q[c] <= 1'b0;
         end
         // Receive FIFO
         if (pop_c[c]) begin
            fifo_q[c*3] <= fifo_q[c*3+1];
            fifo_q[c*3+1] <= fifo_q[c*3+2];
            first_q[c] <= 1'b0;
         end
         if (push_c[c]) begin
            if (fcnt_q[c] != `DSP_FIFO_DEPTH || pop_c[c])
               fifo_q[c*3+fcnt_q[c]-pop_c[c]] <= rsh_q[c];
         end
         fcnt_q[c] <= fcnt_q[c] + ((push_c[c] && (fcnt_q[c] != `DSP_FIFO_DEPTH || pop_c[c])) ? 2'h1 : 2'h0)
                    - (pop_c[c] ? 2'h1 : 2'h0);
         // External input change
         mprev_q[c] <= {cts_w[c], dcd_w[c], ri_w[c]};
         // Host writes
         if (wr_st_w && bsel_w == c[0]) begin
            if (!csel_w) begin
               thr_q[c] <= d_w;
               thr_full_q[c] <= 1'b1;
               txip_q[c] <= 1'b0;
            end else if (ptr_q[c] == `DSP_PTR_CMD) begin
               case (cmd_w)
                  `DSP_CMD_EXT_RST:  extip_q[c] <= 1'b0;
                  `DSP_CMD_RX_NEXT:  arm_q[c] <= 1'b1;
                  `DSP_CMD_TXIP_RST: txip_q[c] <= 1'b0;
                  `DSP_CMD_ERR_RST:  {ovr_q[c], fe_q[c]} <= 2'h0;
                  `DSP_CMD_CH_RST: begin
                     {mode_q[c], rxp_q[c], misc_q[c], txp_q[c]} <= 32'h00000000;
                     {thr_full_q[c], txip_q[c], extip_q[c], ovr_q[c], fe_q[c]} <= 5'h00;
                     tcnt_q[c] <= 4'h0;
                     rbusy_q[c] <= 1'b0;
                     fcnt_q[c] <= 2'h0;
                     arm_q[c] <= 1'b1;
                  end
                  default: ;
               endcase
               if (cmd_w != `DSP_CMD_CH_RST)
                  ptr_q[c] <= d_w[2:0];
            end else begin
               case (ptr_q[c])
                  `DSP_PTR_MODE: mode_q[c] <= d_w;
                  `DSP_PTR_VEC:  if (c == 1) vec_q <= d_w;
                  `DSP_PTR_RXP:  rxp_q[c] <= d_w;
                  `DSP_PTR_MISC: misc_q[c] <= d_w;
                  `DSP_PTR_TXP:  txp_q[c] <= d_w;
                  default: ;
               endcase
               ptr_q[c] <= `DSP_PTR_CMD;
            end
         end
         if (rd_st_w && csel_w && bsel_w == c[0])
            ptr_q[c] <= `DSP_PTR_CMD;
         // Events set after clears so a coincident event survives
         if (push_c[c] && fcnt_q[c] == `DSP_FIFO_DEPTH && !pop_c[c])
            ovr_q[c] <= 1'b1;
         if (tcnt_q[c] == 4'h0 && thr_full_q[c] && txp_q[c][`DSP_TXP_TXEN] && mode_q[c][`DSP_MODE_TXIE])
            txip_q[c] <= 1'b1;
         if (push_c[c] && !rxd_w[c])
            fe_q[c] <= 1'b1;
         if (push_c[c] && arm_q[c] &&
             mode_q[c][`DSP_MODE_RXM_MSB:`DSP_MODE_RXM_LSB] == `DSP_RXM_FIRST) begin
            first_q[c] <= 1'b1;
            arm_q[c] <= 1'b0;
         end
         if (mode_q[c][`DSP_MODE_EXTIE] && mprev_q[c] != {cts_w[c], dcd_w[c], ri_w[c]})
            extip_q[c] <= 1'b1;
      end
      // Interrupt status frozen during opcode fetch
      if (m1_n_w)
         ip_q <= ip_raw;
      if (ack_st_w && chain_w && hit)
         ius_q <= ius_q | (6'h01 << sel);
      else if (return_from_irq_opcode_w)
         ius_q <= ius_q & ~ius_low_w;
      irq_n_q <= ~(hit & chain_w);
      chain_out_q <= chain_w & ~(|ip_q) & ~(|ius_q);
      if (ack_st_w && chain_w && hit) begin
         dout_q <= vec_out;
         doe_n_q <= 1'b0;
      end else if (rd_st_w) begin
         dout_q <= rd_val;
         doe_n_q <= 1'b0;
      end else if (!acc_w && !ack_w) begin
         doe_n_q <= 1'b1;
      end
   end
end
// ----------------------------------------
// Outputs
// ----------------------------------------
assign data_out         = dout_q;
assign data_oe_n_out    = doe_n_q;
assign irq_n_out        = irq_n_q;
assign irq_oe_n_out     = irq_n_q;
assign chain_enable_out = chain_out_q;
assign txd_out          = txd_q;
endmodule // dsp_host_port

/* dsp_host_port_monitor.sv */
module dsp_host_port_monitor #(
   parameter [15:0] BIT_DIV = 16'h0010
) (
   input wire       mclk_in,
   input wire       rst_b_in,
   input wire       chip_sel_n_in,
   input wire       rd_n_in,
   input wire       io_request_strobe_n_in,
   input wire       opcode_fetch_strobe_n_in,
   input wire       chain_enable_in,
   input wire       data_oe_n_out,
   input wire       irq_n_out,
   input wire       chain_enable_out,
   input wire [1:0] txd_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----
   // Low run length on channel A line
   // ----
   logic [15:0] zl_q;
   wire         acc_rd = !chip_sel_n_in && !io_request_strobe_n_in && !rd_n_in && opcode_fetch_strobe_n_in;
   wire         acc_wr = !chip_sel_n_in && rd_n_in && opcode_fetch_strobe_n_in;
   wire         ack    = !opcode_fetch_strobe_n_in && !io_request_strobe_n_in;
   always @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) zl_q <= 16'h0000;
      else zl_q <= txd_out[0] ? 16'h0000 : zl_q + 16'h0001;
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   AST_RD_ANSWER: assert property (acc_rd [*5] |-> !data_oe_n_out)
      else $error("read not answered");
   AST_WR_QUIET: assert property (acc_wr [*6] |-> data_oe_n_out)
      else $error("bus driven in write");
   AST_IDLE_QUIET: assert property (io_request_strobe_n_in [*6] |-> data_oe_n_out)
      else $error("bus driven while idle");
   AST_CHAIN_BLOCK: assert property (!irq_n_out && !$past(irq_n_out) |-> !chain_enable_out)
      else $error("chain open while requesting");
   AST_CHAIN_LOW: assert property (!chain_enable_in [*4] |-> !chain_enable_out)
      else $error("chain out high with chain in low");
   AST_FREEZE: assert property (!opcode_fetch_strobe_n_in [*6] |-> $stable(irq_n_out))
      else $error("request moved during fetch");
   AST_VEC_CHAIN: assert property ($fell(data_oe_n_out) && ack |-> chain_enable_in)
      else $error("vector without chain");
   AST_ACK_VEC: assert property ((ack && chain_enable_in && !irq_n_out) [*3] |-> ##2 !data_oe_n_out)
      else $error("no vector on acknowledge");
   AST_TX_BITS: assert property ($rose(txd_out[0]) |-> (zl_q % BIT_DIV) == 16'h0000)
      else $error("bit time wrong");
endmodule // dsp_host_port_monitor

bind dsp_host_port dsp_host_port_monitor #(.BIT_DIV(BIT_DIV)) i_mon (.mclk_in, .rst_b_in, .chip_sel_n_in,
   .rd_n_in, .io_request_strobe_n_in, .opcode_fetch_strobe_n_in, .chain_enable_in, .data_oe_n_out,
   .irq_n_out, .chain_enable_out, .txd_out);

/* dsp_host_model.sv */
module dsp_host_model (
   input  wire        mclk_in,
   input  wire        data_oe_n_in,
   input  wire  [7:0] rdata_in,
   output logic       cs_n_out,
   output logic       rd_n_out,
   output logic       ioreq_n_out,
   output logic       fetch_n_out,
   output logic       bsel_out,
   output logic       csel_out,
   output logic       chain_out,
   output logic [7:0] wdata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {cs_n_out, rd_n_out, ioreq_n_out, fetch_n_out} = 4'hF;
      {bsel_out, csel_out, chain_out} = 3'h0;
      wdata_out = 8'h00;
   end
   // ----
   // Bus cycles
   // ----
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge mclk_in);
         wdata_out <= ~wdata_out;
      end
   endtask
   task automatic acc(input logic b, c, r, input logic [7:0] d, output logic [7:0] q);
      @(posedge mclk_in);
      {cs_n_out, ioreq_n_out, rd_n_out} <= {2'b00, r};
      {bsel_out, csel_out, wdata_out} <= {b, c, d};
      repeat (6) @(posedge mclk_in);
      q = (data_oe_n_in === 1'b0) ? rdata_in : 8'hXX;
      {cs_n_out, ioreq_n_out, rd_n_out} <= 3'h7;
      idle(4);
   endtask
   task automatic wreg(input logic b, input logic [2:0] p, input logic [7:0] v);
      logic [7:0] q;
      acc(b, 1'b1, 1'b1, {5'h00, p}, q);
      acc(b, 1'b1, 1'b1, v, q);
   endtask
   task automatic rreg(input logic b, input logic [2:0] p, output logic [7:0] q);
      acc(b, 1'b1, 1'b1, {5'h00, p}, q);
      acc(b, 1'b1, 1'b0, 8'h00, q);
   endtask
   task automatic ack(output logic [7:0] q);
      @(posedge mclk_in);
      {fetch_n_out, ioreq_n_out} <= 2'b00;
      repeat (6) @(posedge mclk_in);
      q = (data_oe_n_in === 1'b0) ? rdata_in : 8'hXX;
      {fetch_n_out, ioreq_n_out} <= 2'b11;
      idle(4);
   endtask
   task automatic fetch(input logic [7:0] d);
      @(posedge mclk_in);
      {fetch_n_out, wdata_out} <= {1'b0, d};
      repeat (4) @(posedge mclk_in);
      fetch_n_out <= 1'b1;
      repeat (3) @(posedge mclk_in);
      idle(2);
   endtask
   task automatic chain(input logic e);
      @(posedge mclk_in);
      chain_out <= e;
   endtask
endmodule // dsp_host_model

/* dsp_host_port_tb.sv */
`include "dsp_regs.vh"
module dsp_host_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam [15:0] BD = 16'h0004;
   logic       mclk_in, rst_b_in, ovr;
   logic [1:0] cts_n, dcd_n, ring_n;
   logic [7:0] q, v;
   logic [7:0] rxq [2][$];
   wire        cs_n, rd_n, ioreq_n, fetch_n, bsel, csel, chain_i, oe_n, irq_oe_n, chain_o;
   wire  [7:0] wd, rdat;
   wire  [1:0] txd;
   wire        irq_line = irq_oe_n ? 1'b1 : 1'b0;
   int         fail_count, n_tests;
   dsp_host_port #(.BIT_DIV(BD)) i_dut (.mclk_in, .rst_b_in, .chip_sel_n_in(cs_n), .rd_n_in(rd_n),
      .io_request_strobe_n_in(ioreq_n), .opcode_fetch_strobe_n_in(fetch_n), .chan_b_sel_in(bsel),
      .ctrl_sel_in(csel), .data_in(wd), .chain_enable_in(chain_i), .cts_n_in(cts_n), .dcd_n_in(dcd_n),
      .ring_indicator_n_in(ring_n), .rxd_in(txd), .data_out(rdat), .data_oe_n_out(oe_n), .irq_n_out(),
      .irq_oe_n_out(irq_oe_n), .chain_enable_out(chain_o), .txd_out(txd));
   dsp_host_model i_host (.mclk_in, .data_oe_n_in(oe_n), .rdata_in(rdat), .cs_n_out(cs_n), .rd_n_out(rd_n),
      .ioreq_n_out(ioreq_n), .fetch_n_out(fetch_n), .bsel_out(bsel), .csel_out(csel), .chain_out(chain_i),
      .wdata_out(wd));
   // ----
   // Checking helpers
   // ----
   task automatic chk(input string n, input logic [7:0] e, g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [7:0] st0(int ch);
      return {2'b00, ~cts_n[ch], ~ring_n[ch], ~dcd_n[ch], 3'h4};
   endfunction
   task automatic send(input int ch, input logic [7:0] c);
      logic [9:0] f;
      int n;
      fork
         i_host.acc(ch[0], 1'b0, 1'b1, c, q);
         begin
            n = 0;
            while (txd[ch] !== 1'b0 && n < 200) begin @(posedge mclk_in); n++; end
            repeat (BD / 2) @(posedge mclk_in);
            for (int i = 0; i < 10; i++) begin f[i] = txd[ch]; repeat (BD) @(posedge mclk_in); end
         end
      join
      chk("frame data", c, f[8:1]);
      chk("frame ends", 8'h02, {6'h00, f[9], f[0]});
      if (rxq[ch].size() < 3) rxq[ch].push_back(c);
      else ovr = 1'b1;
   endtask
   task automatic wirq;
      int n;
      n = 0;
      while (irq_line !== 1'b0 && n < 300) begin @(posedge mclk_in); n++; end
      chk("irq line", 8'h00, {7'h00, irq_line});
   endtask
   task automatic rx(input int ch);
      i_host.acc(ch[0], 1'b0, 1'b0, 8'h00, q);
      chk("rx data", rxq[ch].pop_front(), q);
   endtask
   initial begin
      mclk_in = 1'b0;
      forever #4 mclk_in = ~mclk_in;
   end
   initial begin
      #160000;
      fail_count++;
      wrap_up;
   end
   initial begin
      void'($urandom(81652));
      {rst_b_in, ovr, cts_n, dcd_n, ring_n} = 8'h3F;
      repeat (5) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      for (int ch = 0; ch < 2; ch++) begin
         @(posedge mclk_in);
         {cts_n, dcd_n, ring_n} <= 6'($urandom);
         i_host.acc(ch[0], 1'b1, 1'b0, 8'h00, q);
         chk("primary status", st0(ch), {2'b00, q[5:0]});
      end
      for (int c = 2; c < 7; c++) i_host.acc(1'b0, 1'b1, 1'b1, 8'(c << 3), q);
      $display("test reset done");
      v = 8'($urandom);
      i_host.wreg(1'b1, `DSP_PTR_VEC, v);
      i_host.wreg(1'b0, `DSP_PTR_VEC, ~v);
      i_host.rreg(1'b1, `DSP_PTR_VEC, q);
      chk("vector", v, q);
      i_host.acc(1'b1, 1'b1, 1'b0, 8'h00, q);
      chk("pointer back", st0(1), {2'b00, q[5:0]});
      $display("test vector done");
      for (int ch = 0; ch < 2; ch++) begin
         i_host.wreg(ch[0], `DSP_PTR_RXP, 8'h01);
         i_host.wreg(ch[0], `DSP_PTR_TXP, 8'h08);
      end
      for (int i = 0; i < 4; i++) send(0, 8'($urandom));
      send(1, 8'($urandom));
      i_host.rreg(1'b0, 3'h1, q);
      chk("overrun", {7'h00, ovr}, {7'h00, q[5]});
      for (int ch = 0; ch < 2; ch++) while (rxq[ch].size() > 0) rx(ch);
      i_host.acc(1'b0, 1'b1, 1'b1, {2'b00, `DSP_CMD_ERR_RST, 3'h0}, q);
      i_host.rreg(1'b0, 3'h1, q);
      chk("errors cleared", 8'h01, {q[5], 6'h00, q[0]});
      $display("test serial done");
      i_host.wreg(1'b1, `DSP_PTR_MODE, 8'h14);
      i_host.wreg(1'b0, `DSP_PTR_MODE, 8'h10);
      i_host.chain(1'b1);
      send(1, 8'($urandom));
      send(0, 8'($urandom));
      wirq;
      chk("chain blocked", 8'h00, {7'h00, chain_o});
      i_host.ack(q);
      chk("vector a", (v & 8'hF1) | 8'h0C, q);
      rx(0);
      chk("in service", 8'h00, {7'h00, chain_o});
      i_host.fetch(`DSP_RETURN_FROM_IRQ_OPCODE_B0);
      i_host.fetch(`DSP_RETURN_FROM_IRQ_OPCODE_B1);
      wirq;
      i_host.ack(q);
      chk("vector b", (v & 8'hF1) | 8'h04, q);
      rx(1);
      i_host.acc(1'b0, 1'b1, 1'b1, {2'b00, `DSP_CMD_RETURN_FROM_IRQ_OPCODE, 3'h0}, q);
      i_host.chain(1'b0);
      repeat (5) @(posedge mclk_in);
      chk("chain follows low", 8'h00, {7'h00, chain_o});
      i_host.chain(1'b1);
      repeat (5) @(posedge mclk_in);
      chk("chain follows high", 8'h01, {7'h00, chain_o});
      $display("test interrupt done");
      wrap_up;
   end
endmodule // dsp_host_port_tb
